// File: core/wost_timer.sv
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
module wost_timer
    import wost_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [DATA_W-1:0] RD_DATA,
    // Pins and neighbours
    input wire logic EXT_TRIGGER_PIN,
    input wire logic COMPANION_UFL,
    output logic PULSE_OUT_PIN,
    output logic TIMER_IRQ,
    output logic PIN_IRQ
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic count_start_bit;
    logic count_status_flag;
    logic [4:0] io_ctrl;
    wost_src_type src_sel;
    logic [7:0] pre_reload;
    logic [7:0] sec_reload;
    logic [7:0] pri_reload;
    logic [7:0] pre_cnt;
    logic [7:0] cnt;
    logic [2:0] div;
    logic pin_prev;
    wost_arm_type arm;
    wost_phase_type phase;
    logic tick;
    logic pin_rise;
    logic pin_fall;
    logic trig_edge;
    logic int_edge;
    logic trigger;
    logic kill;
    logic active;
    logic shot_end;
    logic pri_ufl;
    logic wr_ctrl;
    logic wr_osc;
    logic wr_stat;
    logic next_out;

    // Write decodes, one cycle strobes from the master
    assign wr_ctrl = WR_EN && (ADDR == ADDR_CTRL);
    assign wr_osc = WR_EN && (ADDR == ADDR_OSC);
    assign wr_stat = WR_EN && (ADDR == ADDR_STAT);

    // ----------------------------------------------------------------
    // Count source
    // ----------------------------------------------------------------
    // Free running divider; f2 and f8 are one-cycle enables off it
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            div <= 3'h0;
        end else begin
            div <= div + 3'h1;
        end
    end

    // Source select picks one tick per count source cycle
    always_comb begin
        case (src_sel)
            WOST_SRC_F1: tick = 1'b1;
            WOST_SRC_F2: tick = div[0];
            WOST_SRC_F8: tick = (div == DIV8_LAST);
            WOST_SRC_COMP: tick = COMPANION_UFL;
            default: tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Pin edges and triggers
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_prev <= 1'b1;
        end else begin
            pin_prev <= EXT_TRIGGER_PIN;
        end
    end

    assign pin_rise = EXT_TRIGGER_PIN && !pin_prev;
    assign pin_fall = !EXT_TRIGGER_PIN && pin_prev;

    // Timer edge and interrupt edge are chosen independently unless both_edge_select makes both take either edge
    always_comb begin
        if (io_ctrl[IOC_BOTH]) begin
            trig_edge = pin_rise || pin_fall;
            int_edge = pin_rise || pin_fall;
        end else begin
            trig_edge = io_ctrl[IOC_TEDGE] ? pin_rise : pin_fall;
            int_edge = io_ctrl[IOC_ISENSE] ? pin_rise : pin_fall;
        end
    end

    // Pin only triggers when enabled; otherwise a plain interrupt input
    assign trigger = (wr_osc && WR_DATA[OSC_START])
        || (io_ctrl[IOC_PTEN] && trig_edge);

    // Any stop condition while not idle
    assign kill = !count_start_bit
        || (wr_osc && WR_DATA[OSC_STOP])
        || (wr_ctrl && (WR_DATA[CTRL_FSTOP] || !WR_DATA[CTRL_START]));

    assign active = (arm == WOST_WAIT);
    assign pri_ufl = tick && (pre_cnt == 8'h00) && (cnt == 8'h00);
    assign shot_end = active && (phase == WOST_PH_SEC) && pri_ufl;

    // ----------------------------------------------------------------
    // Control register and count status
    // ----------------------------------------------------------------
    // Forced stop clears start and status immediately; otherwise status follows start at a tick
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            count_start_bit <= 1'b0;
            count_status_flag <= 1'b0;
        end else begin
            if (wr_ctrl && WR_DATA[CTRL_FSTOP]) begin
                count_start_bit <= 1'b0;
                count_status_flag <= 1'b0;
            end else begin
                if (wr_ctrl) begin
                    count_start_bit <= WR_DATA[CTRL_START];
                end
                if (tick) begin
                    count_status_flag <= count_start_bit;
                end
            end
        end
    end

    // Remaining configuration registers
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            io_ctrl <= RST_IOC;
            src_sel <= wost_src_type'(RST_SRC);
        end else if (WR_EN) begin
            if (ADDR == ADDR_IOC) begin
                io_ctrl <= WR_DATA[4:0];
            end
            if (ADDR == ADDR_SRC) begin
                src_sel <= wost_src_type'(WR_DATA[1:0]);
            end
        end
    end

    // Reload registers always take the write
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pre_reload <= RST_COUNT;
            sec_reload <= RST_COUNT;
            pri_reload <= RST_COUNT;
        end else if (WR_EN) begin
            if (ADDR == ADDR_PRE) begin
                pre_reload <= WR_DATA;
            end
            if (ADDR == ADDR_SEC) begin
                sec_reload <= WR_DATA;
            end
            if (ADDR == ADDR_PRI) begin
                pri_reload <= WR_DATA;
            end
        end
    end

    // ----------------------------------------------------------------
    // One-shot sequencer
    // ----------------------------------------------------------------
    // Trigger taken only when idle and counting enabled
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            arm <= WOST_IDLE;
        end else if (arm != WOST_IDLE && kill) begin
            arm <= WOST_IDLE;
        end else begin
            case (arm)
                WOST_IDLE: begin
                    if (trigger && count_status_flag && count_start_bit) begin
                        arm <= WOST_ARM1;
                    end
                end
                // Two tick boundaries give the one to two cycle delay
                WOST_ARM1: begin
                    if (tick) begin
                        arm <= WOST_ARM2;
                    end
                end
                WOST_ARM2: begin
                    if (tick) begin
                        arm <= WOST_WAIT;
                    end
                end
                WOST_WAIT: begin
                    if (shot_end) begin
                        arm <= WOST_IDLE;
                    end
                end
                default: arm <= WOST_IDLE;
            endcase
        end
    end

    // Prescaler and main counter; writes reach the counter only when stopped
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pre_cnt <= RST_COUNT;
            cnt <= RST_COUNT;
            phase <= WOST_PH_OFF;
        end else if ((arm != WOST_IDLE && kill) || shot_end) begin
            // Reload and halt in the same cycle, so the next shot sees new values
            pre_cnt <= pre_reload;
            cnt <= pri_reload;
            phase <= WOST_PH_OFF;
        end else if (arm == WOST_ARM2 && tick) begin
            pre_cnt <= pre_reload;
            cnt <= pri_reload;
            phase <= WOST_PH_PRI;
        end else if (active && tick) begin
            // Each count step costs prescaler+1 ticks
            if (pre_cnt == 8'h00) begin
                pre_cnt <= pre_reload;
                if (cnt == 8'h00) begin
                    cnt <= sec_reload;
                    phase <= WOST_PH_SEC;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end else begin
                pre_cnt <= pre_cnt - 8'h01;
            end
        end else if (arm == WOST_IDLE && WR_EN) begin
            if (ADDR == ADDR_PRE) begin
                pre_cnt <= WR_DATA;
            end
            if (ADDR == ADDR_PRI) begin
                cnt <= WR_DATA;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin outputs and request flags
    // ----------------------------------------------------------------
    // Registered from the next phase so the pin lines up with the counter
    always_comb begin
        if (kill && arm != WOST_IDLE) begin
            next_out = ~io_ctrl[IOC_LEVEL];
        end else if (shot_end) begin
            next_out = ~io_ctrl[IOC_LEVEL];
        end else if (active && phase == WOST_PH_SEC) begin
            next_out = io_ctrl[IOC_LEVEL];
        end else if (active && tick && pre_cnt == 8'h00 && cnt == 8'h00) begin
            next_out = io_ctrl[IOC_LEVEL];
        end else begin
            next_out = ~io_ctrl[IOC_LEVEL];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PULSE_OUT_PIN <= 1'b1;
        end else begin
            PULSE_OUT_PIN <= next_out;
        end
    end

    // Sticky flags: a new event beats a clear in the same cycle
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PIN_IRQ <= 1'b0;
            TIMER_IRQ <= 1'b0;
        end else begin
            if (int_edge) begin
                PIN_IRQ <= 1'b1;
            end else if (wr_stat && WR_DATA[STAT_PIN]) begin
                PIN_IRQ <= 1'b0;
            end
            if (shot_end) begin
                TIMER_IRQ <= 1'b1;
            end else if (wr_stat && WR_DATA[STAT_TMR]) begin
                TIMER_IRQ <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port, data one cycle after the strobe
    // ----------------------------------------------------------------
    // Live counts are returned for prescaler and primary; secondary returns its reload value
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RD_DATA <= 8'h00;
        end else if (RD_EN) begin
            case (ADDR)
                ADDR_CTRL: RD_DATA <= {5'h00, 1'b0, count_status_flag, count_start_bit};
                ADDR_OSC: RD_DATA <= {5'h00, active, 2'b00};
                ADDR_IOC: RD_DATA <= {3'h0, io_ctrl};
                ADDR_SRC: RD_DATA <= {6'h00, src_sel};
                ADDR_PRE: RD_DATA <= pre_cnt;
                ADDR_SEC: RD_DATA <= sec_reload;
                ADDR_PRI: RD_DATA <= cnt;
                ADDR_STAT: RD_DATA <= {6'h00, TIMER_IRQ, PIN_IRQ};
                default: RD_DATA <= 8'h00;
            endcase
        end else begin
            RD_DATA <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_start_gated: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (arm == WOST_IDLE && trigger && !count_status_flag) |=> arm == WOST_IDLE)
        else $error("trigger accepted while count status is 0");

    a_sw_trigger: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (arm == WOST_IDLE && wr_osc && WR_DATA[OSC_START] && count_status_flag
         && count_start_bit) |=> arm == WOST_ARM1)
        else $error("software trigger not taken");

    a_arm_delay: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (arm == WOST_ARM1 && tick && !kill) |=> (arm == WOST_ARM2 && !active))
        else $error("active flag set too early");

    a_wait_begins: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (arm == WOST_ARM2 && tick && !kill)
        |=> (active && phase == WOST_PH_PRI && cnt == $past(pri_reload)))
        else $error("wait period did not begin");

    a_no_retrigger: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (active && trigger && !kill && !tick) |=> (active && $stable(cnt)))
        else $error("retrigger disturbed the count");

    a_pin_flag: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        int_edge |=> PIN_IRQ)
        else $error("pin request flag missed an edge");

    a_to_pulse: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (active && phase == WOST_PH_PRI && pri_ufl && !kill)
        |=> (phase == WOST_PH_SEC && cnt == $past(sec_reload)
             && PULSE_OUT_PIN == $past(io_ctrl[IOC_LEVEL])))
        else $error("secondary period not entered");

    a_shot_end: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (shot_end && !kill) |=> (!active && TIMER_IRQ && cnt == $past(pri_reload)
                                 && PULSE_OUT_PIN == !$past(io_ctrl[IOC_LEVEL])))
        else $error("shot end sequence wrong");

    a_stop_reload: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (arm != WOST_IDLE && kill)
        |=> (arm == WOST_IDLE && pre_cnt == $past(pre_reload)))
        else $error("stop without reload");

    a_idle_level: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (arm == WOST_IDLE && $past(arm) == WOST_IDLE && $stable(io_ctrl))
        |-> PULSE_OUT_PIN == !io_ctrl[IOC_LEVEL])
        else $error("output not inactive while idle");

    a_stopped_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (arm == WOST_IDLE && WR_EN && ADDR == ADDR_PRI) |=> cnt == $past(WR_DATA))
        else $error("stopped write missed the counter");

    c_full_shot: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        shot_end ##1 TIMER_IRQ);
    c_pin_start: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        (arm == WOST_IDLE && io_ctrl[IOC_PTEN] && trig_edge && count_status_flag)
        ##1 arm == WOST_ARM1);
    c_forced: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        active && wr_ctrl && WR_DATA[CTRL_FSTOP]);
endmodule

// File: core/wost_pkg.sv
package wost_pkg;
    // ----------------------------------------------------------------
    // Register map (byte-wide registers, one per address)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] ADDR_CTRL = 3'h0; // timer_control_reg
    localparam logic [2:0] ADDR_OSC = 3'h1; // one_shot_control_reg
    localparam logic [2:0] ADDR_IOC = 3'h2; // timer_io_control_reg
    localparam logic [2:0] ADDR_SRC = 3'h3; // count source select
    localparam logic [2:0] ADDR_PRE = 3'h4; // prescaler_reg
    localparam logic [2:0] ADDR_SEC = 3'h5; // secondary_reg
    localparam logic [2:0] ADDR_PRI = 3'h6; // primary_reg
    localparam logic [2:0] ADDR_STAT = 3'h7; // event flags, write 1 to clear

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_START = 0; // count_start_bit
    localparam int CTRL_STATUS = 1; // count_status_flag, read only
    localparam int CTRL_FSTOP = 2; // forced_stop_bit, write only
    localparam int OSC_START = 0; // one_shot_start_bit, write only
    localparam int OSC_STOP = 1; // one_shot_stop_bit, write only
    localparam int OSC_ACTIVE = 2; // one_shot_active_flag, read only
    localparam int IOC_LEVEL = 0; // pulse_level_select
    localparam int IOC_TEDGE = 1; // trigger_edge_select, 1 = rising
    localparam int IOC_PTEN = 2; // pin_trigger_enable
    localparam int IOC_BOTH = 3; // both_edge_select
    localparam int IOC_ISENSE = 4; // int_edge_sense, 1 = rising
    localparam int STAT_PIN = 0; // interrupt_request_flag of the pin
    localparam int STAT_TMR = 1; // timer interrupt request flag

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_COUNT = 8'hFF;
    localparam logic [4:0] RST_IOC = 5'h00;
    localparam logic [1:0] RST_SRC = 2'h0;

    // ----------------------------------------------------------------
    // Count source divider
    // ----------------------------------------------------------------
    localparam logic [2:0] DIV8_LAST = 3'h7;

    typedef enum logic [1:0] {
        WOST_SRC_F1 = 2'b00,
        WOST_SRC_F2 = 2'b01,
        WOST_SRC_F8 = 2'b10,
        WOST_SRC_COMP = 2'b11
    } wost_src_type;

    typedef enum logic [1:0] {
        WOST_IDLE = 2'b00,
        WOST_ARM1 = 2'b01,
        WOST_ARM2 = 2'b10,
        WOST_WAIT = 2'b11
    } wost_arm_type;

    typedef enum logic [1:0] {
        WOST_PH_OFF = 2'b00,
        WOST_PH_PRI = 2'b01,
        WOST_PH_SEC = 2'b10
    } wost_phase_type;
endpackage

// File: tb/wost_partner.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Trigger source and pulse load beside the one-shot timer
// ----------------------------------------------------------------
module wost_partner (
    // Clock and load side
    input wire logic SYS_CLK,
    input wire logic PULSE_OUT_PIN,
    input wire logic LEVEL,
    // Trigger source side
    output logic EXT_TRIGGER_PIN
);
    int width = 0;
    int run = 0;
    int pulses = 0;
    time t_rise = 0;

    // Pin idles high like a pulled-up active low input, matching the edge detector reset
    initial EXT_TRIGGER_PIN = 1'b1;

    // Load sits straight on the pin, as if the output pin select were enabled

    // Measure each pulse in clock cycles at the active level
    always @(posedge SYS_CLK) begin
        if (PULSE_OUT_PIN === LEVEL) begin
            if (run == 0) t_rise = $time;
            run = run + 1;
        end else if (run != 0) begin
            width = run;
            pulses = pulses + 1;
            run = 0;
        end
    end

    // One edge, held so the edge detector sees it settled
    task automatic drive(input logic v);
        @(posedge SYS_CLK);
        EXT_TRIGGER_PIN <= v;
        repeat (3) @(posedge SYS_CLK);
    endtask
endmodule

// File: tb/wait_one_shot_timer_bench.sv
`timescale 1ns/1ns
module wait_one_shot_timer_bench
    import wost_pkg::*;
;
    logic SYS_CLK = 1'b0;
    logic RSTN;
    logic [2:0] ADDR;
    logic [7:0] WR_DATA;
    logic WR_EN;
    logic RD_EN;
    logic [7:0] RD_DATA;
    logic EXT_TRIGGER_PIN;
    logic COMPANION_UFL = 1'b0;
    logic PULSE_OUT_PIN;
    logic TIMER_IRQ;
    logic PIN_IRQ;
    logic lvl;
    logic got;
    logic [1:0] ufl_div = 2'h0;
    int failures = 0;
    int n_compared = 0;
    int d1;
    int d2;
    int p0;
    int arm_gap = 4;
    int divs[4] = '{1, 2, 8, 4};
    logic [7:0] t_ioc[7] = '{8'h17, 8'h17, 8'h0D, 8'h0D, 8'h05, 8'h05, 8'h13};
    logic t_pin[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic t_go[7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [2:0] s_adr[3] = '{ADDR_OSC, ADDR_CTRL, ADDR_CTRL};
    logic [7:0] s_val[3] = '{8'h02, 8'h00, 8'h05};

    wost_timer u_dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .EXT_TRIGGER_PIN(EXT_TRIGGER_PIN),
        .COMPANION_UFL(COMPANION_UFL), .PULSE_OUT_PIN(PULSE_OUT_PIN),
        .TIMER_IRQ(TIMER_IRQ), .PIN_IRQ(PIN_IRQ));
    wost_partner u_partner (.SYS_CLK(SYS_CLK), .PULSE_OUT_PIN(PULSE_OUT_PIN), .LEVEL(lvl),
        .EXT_TRIGGER_PIN(EXT_TRIGGER_PIN));

    // 10 MHz system clock
    initial begin
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    // Companion underflow every fourth cycle, so its rate is known
    always @(posedge SYS_CLK) begin
        ufl_div <= ufl_div + 2'h1;
        COMPANION_UFL <= (ufl_div == 2'h3);
    end

    // ----------------------------------------------------------------
    // Access and checking tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WR_DATA <= d;
        WR_EN <= 1'b1;
        @(posedge SYS_CLK);
        WR_EN <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge SYS_CLK);
        RD_EN <= 1'b0;
        #1 check(RD_DATA, e);
    endtask

    // Bounded wait for the end of a shot; a few spare cycles let the pulse close
    task automatic wait_irq(output logic g);
        for (int i = 0; i < 400 && TIMER_IRQ !== 1'b1; i++) @(posedge SYS_CLK);
        g = TIMER_IRQ;
        repeat (3) @(posedge SYS_CLK);
    endtask

    // Software shot with a retrigger and a secondary rewrite while active
    task automatic shot(input logic [7:0] nsec, output int d);
        time t0;
        p0 = u_partner.pulses;
        t0 = $time;
        wr(ADDR_OSC, 8'h01);
        // Slow sources need up to two long ticks before the active flag shows
        repeat (arm_gap) @(posedge SYS_CLK);
        rd(ADDR_OSC, 8'h04);
        wr(ADDR_OSC, 8'h01);
        wr(ADDR_SEC, nsec);
        wait_irq(got);
        check(8'(got), 8'h01);
        check(8'(u_partner.pulses - p0), 8'h01);
        rd(ADDR_OSC, 8'h00);
        wr(ADDR_STAT, 8'h03);
        // Rounded, since t0 may sit on an edge or just after one
        d = int'((u_partner.t_rise - t0 + 50) / 100);
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        failures++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        RSTN = 1'b0;
        ADDR = 3'h0;
        WR_DATA = 8'h00;
        WR_EN = 1'b0;
        RD_EN = 1'b0;
        lvl = 1'b0;
        repeat (10) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), (a >= 4 && a <= 6) ? 8'hFF : 8'h00);
        check(8'(PULSE_OUT_PIN), 8'h01);
        wr(ADDR_IOC, 8'h01);
        lvl = 1'b1;
        // The pin is registered behind the new level, so look two edges on
        repeat (2) @(posedge SYS_CLK);
        check(8'(PULSE_OUT_PIN), 8'h00);
        // Prescaler and primary never both zero
        wr(ADDR_PRE, 8'h00);
        wr(ADDR_SEC, 8'h02);
        wr(ADDR_PRI, 8'h03);
        rd(ADDR_PRI, 8'h03);
        wr(ADDR_CTRL, 8'h01);
        repeat (4) @(posedge SYS_CLK);
        rd(ADDR_CTRL, 8'h03);
        shot(8'h02, d1);
        check(8'(u_partner.width), 8'h03);
        rd(ADDR_PRI, 8'h03);
        wr(ADDR_PRI, 8'h07);
        shot(8'h05, d2);
        check(8'(d2 - d1), 8'h04);
        shot(8'h05, d1);
        check(8'(u_partner.width), 8'h06);
        // Every count source, prescaler of two
        wr(ADDR_PRE, 8'h01);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_SRC, 8'(s));
            arm_gap = 2 * divs[s] + 2;
            shot(8'h05, d1);
            check(8'(u_partner.width), 8'(12 * divs[s]));
        end
        // Pin trigger: edges, enable and interrupt sense
        wr(ADDR_SRC, 8'h00);
        wr(ADDR_PRE, 8'h03);
        wr(ADDR_SEC, 8'h00);
        wr(ADDR_IOC, 8'h13);
        // Park the pin low with the trigger off, so the table starts from 0
        u_partner.drive(1'b0);
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_IOC, t_ioc[i]);
            p0 = u_partner.pulses;
            u_partner.drive(t_pin[i]);
            wait_irq(got);
            check(8'(got), 8'(t_go[i]));
            check(8'(u_partner.pulses - p0), 8'(t_go[i]));
            if (!t_ioc[i][3]) check(8'(PIN_IRQ), 8'(t_pin[i] == t_ioc[i][4]));
            wr(ADDR_STAT, 8'h03);
        end
        // Pin edge while active: flag moves, timer does not
        wr(ADDR_IOC, 8'h17);
        u_partner.drive(1'b0);
        wr(ADDR_STAT, 8'h03);
        p0 = u_partner.pulses;
        u_partner.drive(1'b1);
        wr(ADDR_STAT, 8'h01);
        u_partner.drive(1'b0);
        u_partner.drive(1'b1);
        check(8'(PIN_IRQ), 8'h01);
        wait_irq(got);
        check(8'(u_partner.pulses - p0), 8'h01);
        wr(ADDR_STAT, 8'h03);
        // Three ways to stop in mid-wait
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_CTRL, 8'h01);
            repeat (8) @(posedge SYS_CLK);
            p0 = u_partner.pulses;
            wr(ADDR_OSC, 8'h01);
            repeat (6) @(posedge SYS_CLK);
            check(8'(PULSE_OUT_PIN), 8'h00);
            wr(s_adr[k], s_val[k]);
            repeat (80) @(posedge SYS_CLK);
            check(8'(u_partner.pulses - p0), 8'h00);
            check(8'(TIMER_IRQ), 8'h00);
            rd(ADDR_OSC, 8'h00);
            rd(ADDR_PRI, 8'h07);
        end
        conclude();
    end
endmodule
